// ==== dv/exec_unit_assertions.sv ====
/*
  Timing and result checks for exec_unit, attached by bind.
  Assumes single clock, synchronous active-high rst, exec_pkg compiled.
*/
`timescale 1ns/10ps
module exec_unit_assertions #(
  parameter int PC_W = 16,
  parameter int STACK_AW = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic issue,
  input wire logic [3:0] op,
  input wire logic [7:0] rd_val,
  input wire logic [7:0] rr_val,
  input wire logic [2:0] bit_sel,
  input wire logic [PC_W-1:0] pointer,
  input wire logic [PC_W-1:0] abs_target,
  input wire logic [6:0] offset,
  input wire logic [2:0] flag_sel,
  input wire logic next_long,
  input wire logic [exec_pkg::ADDR_W-1:0] addr,
  input wire logic rd,
  input wire logic [exec_pkg::DATA_W-1:0] rdata,
  input wire logic busy,
  input wire logic done,
  input wire logic [PC_W-1:0] pc,
  input wire logic [7:0] status
);
  logic go;
  logic [PC_W-1:0] off_ext;
  assign go = issue && !busy;
  assign off_ext = {{(PC_W-7){offset[6]}}, offset};
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  reset_values_a: assert property ($fell(rst) |-> pc == '0 && status == 8'h00 && !busy && !done)
    else $error("reset values wrong");
  indirect_call_a: assert property (go && op == exec_pkg::OP_INDIRECT_CALL |=> busy[*2] ##1
    (done && pc == $past(pointer, 3) && status == $past(status, 3))) else $error("indirect call wrong");
  direct_call_a: assert property (go && op == exec_pkg::OP_DIRECT_CALL |=> busy[*3] ##1
    (done && pc == $past(abs_target, 4) && status == $past(status, 4))) else $error("direct call wrong");
  sub_return_a: assert property (go && op == exec_pkg::OP_SUBROUTINE_RETURN |=> busy[*3] ##1
    (done && status == $past(status, 4))) else $error("return timing wrong");
  int_return_a: assert property (go && op == exec_pkg::OP_INTERRUPT_RETURN |=> busy[*3] ##1
    (done && status[7] && (status & 8'h7f) == ($past(status, 4) & 8'h7f))) else $error("interrupt return wrong");
  compare_flags_a: assert property (go && op == exec_pkg::OP_REGISTER_COMPARE |=> done && !busy &&
    status[1] == ($past(rd_val) == $past(rr_val)) && status[0] == ($past(rd_val) < $past(rr_val)))
    else $error("compare flags wrong");
  reg_skip_a: assert property (go && op == exec_pkg::OP_SKIP_REG_BIT_SET && rr_val[bit_sel] && next_long
    |=> busy[*2] ##1 (done && pc == $past(pc, 3) + 2'h3)) else $error("long skip wrong");
  branch_taken_a: assert property (go && op == exec_pkg::OP_BRANCH_FLAG_SET && status[flag_sel]
    |=> busy ##1 (done && pc == $past(pc, 2) + $past(off_ext, 2) + 1'b1)) else $error("branch target wrong");
  branch_fall_a: assert property (go && op == exec_pkg::OP_BRANCH_FLAG_CLEAR && status[flag_sel]
    |=> done && !busy && pc == $past(pc) + 1'b1) else $error("branch fall through wrong");
  read_data_a: assert property (rd && addr == exec_pkg::ADDR_STATUS |=> rdata == $past(status))
    else $error("status read wrong");
  cover property (go && op == exec_pkg::OP_DIRECT_CALL);
  cover property (go && op == exec_pkg::OP_INTERRUPT_RETURN);
  cover property (go && op == exec_pkg::OP_BRANCH_FLAG_SET && status[flag_sel]);
endmodule

bind exec_unit exec_unit_assertions #(.PC_W(PC_W), .STACK_AW(STACK_AW)) u_exec_unit_assertions (
  .clock(clock), .rst(rst), .issue(issue), .op(op), .rd_val(rd_val), .rr_val(rr_val),
  .bit_sel(bit_sel), .pointer(pointer), .abs_target(abs_target), .offset(offset),
  .flag_sel(flag_sel), .next_long(next_long), .addr(addr), .rd(rd), .rdata(rdata),
  .busy(busy), .done(done), .pc(pc), .status(status));

// ==== dv/tb_exec_unit.sv ====
/*
  Random instruction stream with equal-operand corner cases for exec_unit.
  Assumes exec_pkg compiled first and the checker bound separately.
*/
`timescale 1ns/10ps
module tb_exec_unit;
  logic clock = 0, rst = 1, issue = 0, next_long = 0, wr = 0, rd = 0;
  logic [3:0] op = 0, o;
  logic [7:0] rd_val = 0, rr_val = 0, imm = 0, io_val = 0, wdata = 0, rdata, status, exp_st;
  logic [2:0] bit_sel = 0, flag_sel = 0, addr = 0;
  logic [15:0] pointer = 0, abs_target = 0, pc, exp_pc;
  logic [6:0] offset = 0;
  logic busy, done;
  logic [15:0] stk[$];
  logic [31:0] seed = 32'haa02;
  int errors = 0, check_count = 0, cyc = 0, exp_n, n;
  exec_unit u_exec_unit (.clock(clock), .rst(rst), .issue(issue), .op(op), .rd_val(rd_val),
    .rr_val(rr_val), .imm(imm), .bit_sel(bit_sel), .io_val(io_val), .pointer(pointer),
    .abs_target(abs_target), .offset(offset), .flag_sel(flag_sel), .next_long(next_long),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .busy(busy), .done(done),
    .pc(pc), .status(status));
  initial begin
    forever #12.5 clock = ~clock;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      test_done();
    end
  end
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 0;
  endtask
  task automatic rreg(input logic [2:0] a, input logic [7:0] e);
    @(posedge clock);
    rd <= 1;
    addr <= a;
    @(posedge clock);
    rd <= 0;
    #1 chk("rdata", e, rdata);
  endtask
  // Expected pc, flags and length from the operands held at issue
  function automatic void predict();
    logic [8:0] r;
    logic [4:0] h;
    logic [7:0] s;
    logic [15:0] p;
    logic c, t;
    int k;
    s = (op == exec_pkg::OP_COMPARE_IMMEDIATE) ? imm : rr_val;
    c = (op == exec_pkg::OP_COMPARE_WITH_CARRY) & exp_st[0];
    r = {1'b0, rd_val} - {1'b0, s} - c;
    h = {1'b0, rd_val[3:0]} - {1'b0, s[3:0]} - c;
    p = exp_pc;
    exp_pc = p + 16'h1;
    t = 0;
    k = 0;
    exp_n = 1;
    case (op)
      exec_pkg::OP_INDIRECT_CALL: begin
        stk.push_back(p + 16'h1);
        exp_pc = pointer;
        exp_n = 3;
      end
      exec_pkg::OP_DIRECT_CALL: begin
        stk.push_back(p + 16'h2);
        exp_pc = abs_target;
        exp_n = 4;
      end
      exec_pkg::OP_SUBROUTINE_RETURN, exec_pkg::OP_INTERRUPT_RETURN: begin
        exp_pc = stk.pop_back();
        exp_n = 4;
        exp_st[7] = exp_st[7] | (op == exec_pkg::OP_INTERRUPT_RETURN);
      end
      exec_pkg::OP_REGISTER_COMPARE, exec_pkg::OP_COMPARE_WITH_CARRY, exec_pkg::OP_COMPARE_IMMEDIATE: begin
        exp_st[1] = (r[7:0] == 8'h00) & ((op != exec_pkg::OP_COMPARE_WITH_CARRY) | exp_st[1]);
        exp_st[0] = r[8];
        exp_st[2] = r[7];
        exp_st[3] = (rd_val[7] & ~s[7] & ~r[7]) | (~rd_val[7] & s[7] & r[7]);
        exp_st[5] = h[4];
      end
      exec_pkg::OP_COMPARE_SKIP_EQUAL: t = rd_val == rr_val;
      exec_pkg::OP_SKIP_REG_BIT_CLEAR: t = !rr_val[bit_sel];
      exec_pkg::OP_SKIP_REG_BIT_SET: t = rr_val[bit_sel];
      exec_pkg::OP_SKIP_IO_BIT_CLEAR: t = !io_val[bit_sel];
      exec_pkg::OP_SKIP_IO_BIT_SET: t = io_val[bit_sel];
      default: t = exp_st[flag_sel] ^ (op == exec_pkg::OP_BRANCH_FLAG_CLEAR);
    endcase
    if (op >= exec_pkg::OP_BRANCH_FLAG_SET) k = 2;
    else if (op == exec_pkg::OP_COMPARE_SKIP_EQUAL || op >= exec_pkg::OP_SKIP_REG_BIT_CLEAR) k = 1;
    if (t && k == 1) begin
      exp_pc = p + 16'h2 + next_long;
      exp_n = 2 + next_long;
    end
    if (t && k == 2) begin
      exp_pc = p + {{9{offset[6]}}, offset} + 16'h1;
      exp_n = 2;
    end
  endfunction
  task automatic run_op();
    @(posedge clock);
    issue <= 1;
    @(posedge clock);
    issue <= 0;
    #1 predict();
    n = 1;
    while (done !== 1'b1 && n < 8) begin
      @(posedge clock);
      #1 n++;
    end
    chk("cycles", 16'(exp_n), 16'(n));
    chk("pc", exp_pc, pc);
    chk("status", exp_st, status);
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst <= 0;
    rreg(exec_pkg::ADDR_STATUS, 8'h00);
    rreg(exec_pkg::ADDR_STACK_PTR, 8'h0f);
    rreg(3'h5, 8'h00);
    wreg(exec_pkg::ADDR_PC_LO, 8'h34);
    wreg(exec_pkg::ADDR_PC_HI, 8'h12);
    rreg(exec_pkg::ADDR_PC_HI, 8'h12);
    exp_pc = 16'h1234;
    $display("test regs done");
    repeat (300) begin
      seed = lfsr(seed);
      o = 4'(seed[3:0] % 14);
      // Keep the stack within depth so wrap never hides a lost entry
      if ((o < 2 && stk.size() > 13) || ((o == 2 || o == 3) && stk.size() == 0)) o = 4'h5;
      exp_st = seed[15:8];
      wreg(exec_pkg::ADDR_STATUS, seed[15:8]);
      seed = lfsr(seed);
      op <= o;
      rd_val <= seed[7:0];
      rr_val <= seed[8] ? seed[7:0] : seed[15:8];
      imm <= seed[9] ? seed[7:0] : seed[23:16];
      io_val <= seed[23:16];
      bit_sel <= seed[26:24];
      flag_sel <= seed[29:27];
      next_long <= seed[30];
      offset <= seed[22:16];
      pointer <= seed[31:16];
      abs_target <= seed[15:0] ^ 16'h5a5a;
      run_op();
      rreg(exec_pkg::ADDR_STATUS, exp_st);
    end
    $display("test ops done");
    // Less travelled register paths: pc low, state, sp write, refused write
    rreg(exec_pkg::ADDR_PC_LO, exp_pc[7:0]);
    rreg(exec_pkg::ADDR_STATE, 8'h00);
    wreg(exec_pkg::ADDR_STACK_PTR, 8'h05);
    rreg(exec_pkg::ADDR_STACK_PTR, 8'h05);
    wreg(exec_pkg::ADDR_STATE, 8'h07);
    rreg(exec_pkg::ADDR_STATE, 8'h00);
    // Reset again in mid-run; state must return to its reset values
    @(posedge clock);
    rst <= 1;
    repeat (2) @(posedge clock);
    rst <= 0;
    rreg(exec_pkg::ADDR_PC_LO, 8'h00);
    rreg(exec_pkg::ADDR_STACK_PTR, 8'h0f);
    rreg(exec_pkg::ADDR_STATUS, 8'h00);
    $display("test reset done");
    test_done();
  end
endmodule

// ==== hw/exec_pkg.sv ====
/*
  Shared constants for the compare, skip, call and return execution unit:
  operation codes, state names, register offsets, flag positions, cycle
  counts and reset values.
  Assumes it is compiled before every design file that names it.
*/
package exec_pkg;

  // Operation presented by the decode path with the issue strobe
  typedef enum logic [3:0] {
    OP_INDIRECT_CALL,
    OP_DIRECT_CALL,
    OP_SUBROUTINE_RETURN,
    OP_INTERRUPT_RETURN,
    OP_COMPARE_SKIP_EQUAL,
    OP_REGISTER_COMPARE,
    OP_COMPARE_WITH_CARRY,
    OP_COMPARE_IMMEDIATE,
    OP_SKIP_REG_BIT_CLEAR,
    OP_SKIP_REG_BIT_SET,
    OP_SKIP_IO_BIT_CLEAR,
    OP_SKIP_IO_BIT_SET,
    OP_BRANCH_FLAG_SET,
    OP_BRANCH_FLAG_CLEAR
  } op_t;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_WAIT
  } fsm_t;

  // Register port map
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_PC_LO = 3'h1;
  localparam logic [2:0] ADDR_PC_HI = 3'h2;
  localparam logic [2:0] ADDR_STACK_PTR = 3'h3;
  localparam logic [2:0] ADDR_STATE = 3'h4;

  // Status register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // Cycle counts per instruction, issue cycle included
  localparam logic [2:0] CYC_INDIRECT_CALL = 3'h3;
  localparam logic [2:0] CYC_DIRECT_CALL = 3'h4;
  localparam logic [2:0] CYC_RETURN = 3'h4;
  localparam logic [2:0] CYC_COMPARE = 3'h1;
  localparam logic [2:0] CYC_BRANCH_TAKEN = 3'h2;
  localparam logic [2:0] CYC_NOT_TAKEN = 3'h1;
  // Remaining count at which a return reads the stack
  localparam logic [2:0] RETURN_READ_AT = 3'h3;

  // Instruction lengths in words
  localparam int LEN_SHORT = 1;
  localparam int LEN_LONG = 2;

  // Default widths and reset values
  localparam int DEF_PC_W = 16;
  localparam int DEF_STACK_AW = 4;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

endpackage

// ==== hw/exec_unit.sv ====
/*
  Execution unit for calls, returns, compares, compare-skip, bit-test
  skips and flag branches of an 8-bit core. Owns the program counter,
  status register and return stack pointer; the stack words sit in
  stack_mem.
  Assumes decode presents one operation per issue pulse with its operands
  valid in that cycle, and that software reaches the state over the plain
  register port.
*/
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/10ps
module exec_unit #(
  parameter int PC_W = exec_pkg::DEF_PC_W,
  parameter int STACK_AW = exec_pkg::DEF_STACK_AW
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic issue,
  input wire logic [3:0] op,
  input wire logic [7:0] rd_val,
  input wire logic [7:0] rr_val,
  input wire logic [7:0] imm,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] io_val,
  input wire logic [PC_W-1:0] pointer,
  input wire logic [PC_W-1:0] abs_target,
  input wire logic [6:0] offset,
  input wire logic [2:0] flag_sel,
  input wire logic next_long,
  input wire logic [exec_pkg::ADDR_W-1:0] addr,
  input wire logic [exec_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [exec_pkg::DATA_W-1:0] rdata,
  output logic busy,
  output logic done,
  output logic [PC_W-1:0] pc,
  output logic [7:0] status
);

  generate
    if (PC_W < 9 || PC_W > 16 || STACK_AW < 1 || STACK_AW > 8) begin : g_bad
      $error("exec_unit: unsupported parameter values");
    end
  endgenerate

  typedef struct packed {
    exec_pkg::fsm_t fsm;
    logic [2:0] cnt;
    logic is_return;
    logic is_irq_return;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] target;
    logic [STACK_AW-1:0] sp;
    logic [7:0] status;
    logic done;
    logic [7:0] rdata;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic mem_we;
  logic mem_re;
  logic [STACK_AW-1:0] mem_addr;
  logic [PC_W-1:0] mem_wdata;
  logic [PC_W-1:0] mem_rdata;

  stack_mem #(
    .AW(STACK_AW),
    .DW(PC_W)
  ) u_stack (
    .clock(clock),
    .rst(rst),
    .we(mem_we),
    .re(mem_re),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // Flags of dst - src - carry; result itself is never kept
  function automatic logic [7:0] compare_flags(
    input logic [7:0] st,
    input logic [7:0] d,
    input logic [7:0] r,
    input logic with_carry
  );
    logic [8:0] diff;
    logic [7:0] res;
    logic [7:0] f;
    logic cin;
    cin = with_carry & st[exec_pkg::FLAG_C];
    diff = {1'b0, d} - {1'b0, r} - {8'h00, cin};
    res = diff[7:0];
    f = st;
    f[exec_pkg::FLAG_C] = diff[8];
    f[exec_pkg::FLAG_H] = (~d[3] & r[3]) | (r[3] & res[3]) | (res[3] & ~d[3]);
    f[exec_pkg::FLAG_V] = (d[7] & ~r[7] & ~res[7]) | (~d[7] & r[7] & res[7]);
    f[exec_pkg::FLAG_N] = res[7];
    // Carry form keeps zero only if it was already set, for multi-byte chains
    if (with_carry) begin
      f[exec_pkg::FLAG_Z] = (res == 8'h00) & st[exec_pkg::FLAG_Z];
    end else begin
      f[exec_pkg::FLAG_Z] = (res == 8'h00);
    end
    return f;
  endfunction

  // Words skipped over when a skip condition holds
  function automatic logic [1:0] skip_words(input logic cond, input logic long_next);
    logic [1:0] w;
    w = 2'h0;
    if (cond) begin
      w = long_next ? 2'(exec_pkg::LEN_LONG) : 2'(exec_pkg::LEN_SHORT);
    end
    return w;
  endfunction

  // Condition of the compare-skip and bit-test skip group
  function automatic logic skip_condition(
    input exec_pkg::op_t code,
    input logic [7:0] d,
    input logic [7:0] r,
    input logic [7:0] io,
    input logic [2:0] sel
  );
    logic c;
    c = 1'b0;
    case (code)
      exec_pkg::OP_COMPARE_SKIP_EQUAL: c = (d == r);
      exec_pkg::OP_SKIP_REG_BIT_CLEAR: c = ~r[sel];
      exec_pkg::OP_SKIP_REG_BIT_SET: c = r[sel];
      exec_pkg::OP_SKIP_IO_BIT_CLEAR: c = ~io[sel];
      exec_pkg::OP_SKIP_IO_BIT_SET: c = io[sel];
      default: c = 1'b0;
    endcase
    return c;
  endfunction

  // Flag test shared by both branch forms
  function automatic logic branch_condition(
    input logic [7:0] st,
    input logic [2:0] sel,
    input logic on_set
  );
    logic c;
    c = on_set ? st[sel] : ~st[sel];
    return c;
  endfunction

  // Register port view; unmapped offsets read as zero
  function automatic logic [7:0] read_view(
    input logic [exec_pkg::ADDR_W-1:0] a,
    input state_t st
  );
    logic [7:0] v;
    case (a)
      exec_pkg::ADDR_STATUS: v = st.status;
      exec_pkg::ADDR_PC_LO: v = st.pc[7:0];
      exec_pkg::ADDR_PC_HI: v = 8'(st.pc[PC_W-1:8]);
      exec_pkg::ADDR_STACK_PTR: v = 8'(st.sp);
      exec_pkg::ADDR_STATE: v = {5'h00, st.cnt};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    logic [1:0] skip;
    logic cond;
    logic [PC_W-1:0] pc_inc;
    logic [PC_W-1:0] pc_long;
    logic [PC_W-1:0] rel;
    skip = 2'h0;
    cond = 1'b0;
    pc_inc = PC_W'(s_reg.pc + PC_W'(exec_pkg::LEN_SHORT));
    pc_long = PC_W'(s_reg.pc + PC_W'(exec_pkg::LEN_LONG));
    rel = PC_W'(pc_inc + {{(PC_W-7){offset[6]}}, offset});
    s_next = s_reg;
    s_next.done = 1'b0;
    mem_we = 1'b0;
    mem_re = 1'b0;
    mem_addr = s_reg.sp;
    mem_wdata = pc_inc;

    if (rd) begin
      s_next.rdata = read_view(addr, s_reg);
    end

    // Software writes first, so an instruction finishing in the same cycle wins
    if (wr) begin
      case (addr)
        exec_pkg::ADDR_STATUS: s_next.status = wdata;
        exec_pkg::ADDR_PC_LO: s_next.pc[7:0] = wdata;
        exec_pkg::ADDR_PC_HI: s_next.pc[PC_W-1:8] = wdata[PC_W-9:0];
        exec_pkg::ADDR_STACK_PTR: s_next.sp = wdata[STACK_AW-1:0];
        default: ;
      endcase
    end

    case (s_reg.fsm)
      exec_pkg::ST_IDLE: begin
        // Issue is only looked at here, so a busy unit drops it silently
        if (issue) begin
          s_next.is_return = 1'b0;
          s_next.is_irq_return = 1'b0;
          case (exec_pkg::op_t'(op))
            // Stack wraps silently at its depth; no overflow indication
            exec_pkg::OP_INDIRECT_CALL: begin
              mem_we = 1'b1;
              mem_wdata = pc_inc;
              s_next.sp = STACK_AW'(s_reg.sp - 1'b1);
              s_next.target = pointer;
              s_next.cnt = 3'(exec_pkg::CYC_INDIRECT_CALL - 3'h1);
              s_next.fsm = exec_pkg::ST_WAIT;
            end
            exec_pkg::OP_DIRECT_CALL: begin
              mem_we = 1'b1;
              mem_wdata = pc_long;
              s_next.sp = STACK_AW'(s_reg.sp - 1'b1);
              s_next.target = abs_target;
              s_next.cnt = 3'(exec_pkg::CYC_DIRECT_CALL - 3'h1);
              s_next.fsm = exec_pkg::ST_WAIT;
            end
            exec_pkg::OP_SUBROUTINE_RETURN: begin
              s_next.sp = STACK_AW'(s_reg.sp + 1'b1);
              s_next.is_return = 1'b1;
              s_next.cnt = 3'(exec_pkg::CYC_RETURN - 3'h1);
              s_next.fsm = exec_pkg::ST_WAIT;
            end
            exec_pkg::OP_INTERRUPT_RETURN: begin
              s_next.sp = STACK_AW'(s_reg.sp + 1'b1);
              s_next.is_return = 1'b1;
              s_next.is_irq_return = 1'b1;
              s_next.cnt = 3'(exec_pkg::CYC_RETURN - 3'h1);
              s_next.fsm = exec_pkg::ST_WAIT;
            end
            exec_pkg::OP_REGISTER_COMPARE: begin
              s_next.status = compare_flags(s_reg.status, rd_val, rr_val, 1'b0);
              s_next.pc = pc_inc;
              s_next.done = 1'b1;
            end
            exec_pkg::OP_COMPARE_WITH_CARRY: begin
              s_next.status = compare_flags(s_reg.status, rd_val, rr_val, 1'b1);
              s_next.pc = pc_inc;
              s_next.done = 1'b1;
            end
            exec_pkg::OP_COMPARE_IMMEDIATE: begin
              s_next.status = compare_flags(s_reg.status, rd_val, imm, 1'b0);
              s_next.pc = pc_inc;
              s_next.done = 1'b1;
            end
            exec_pkg::OP_BRANCH_FLAG_SET, exec_pkg::OP_BRANCH_FLAG_CLEAR: begin
              cond = branch_condition(s_reg.status, flag_sel,
                exec_pkg::op_t'(op) == exec_pkg::OP_BRANCH_FLAG_SET);
              if (cond) begin
                s_next.target = rel;
                s_next.cnt = 3'(exec_pkg::CYC_BRANCH_TAKEN - 3'h1);
                s_next.fsm = exec_pkg::ST_WAIT;
              end else begin
                s_next.pc = pc_inc;
                s_next.done = 1'b1;
              end
            end
            default: begin
              cond = skip_condition(exec_pkg::op_t'(op), rd_val, rr_val, io_val, bit_sel);
              skip = skip_words(cond, next_long);
              // Skipped words cost one extra cycle each
              if (skip == 2'h0) begin
                s_next.pc = pc_inc;
                s_next.done = 1'b1;
              end else begin
                s_next.target = PC_W'(pc_inc + PC_W'(skip));
                s_next.cnt = 3'(skip);
                s_next.fsm = exec_pkg::ST_WAIT;
              end
            end
          endcase
        end
      end
      exec_pkg::ST_WAIT: begin
        s_next.cnt = 3'(s_reg.cnt - 3'h1);
        // Stack word is registered in the memory, ready one cycle later
        if (s_reg.is_return && s_reg.cnt == exec_pkg::RETURN_READ_AT) begin
          mem_re = 1'b1;
          mem_addr = s_reg.sp;
        end
        if (s_reg.cnt == 3'h1) begin
          s_next.fsm = exec_pkg::ST_IDLE;
          s_next.done = 1'b1;
          if (s_reg.is_return) begin
            s_next.pc = mem_rdata;
            if (s_reg.is_irq_return) begin
              s_next.status[exec_pkg::FLAG_I] = 1'b1;
            end
          end else begin
            s_next.pc = s_reg.target;
          end
        end
      end
      default: begin
        s_next.fsm = exec_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_reg.fsm <= exec_pkg::ST_IDLE;
      s_reg.cnt <= 3'h0;
      s_reg.is_return <= 1'b0;
      s_reg.is_irq_return <= 1'b0;
      s_reg.pc <= '0;
      s_reg.target <= '0;
      s_reg.sp <= '1;
      s_reg.status <= exec_pkg::STATUS_RST;
      s_reg.done <= 1'b0;
      s_reg.rdata <= exec_pkg::RDATA_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign busy = (s_reg.fsm == exec_pkg::ST_WAIT);
  assign done = s_reg.done;
  assign pc = s_reg.pc;
  assign status = s_reg.status;
  assign rdata = s_reg.rdata;

endmodule

// ==== hw/stack_mem.sv ====
/*
  Return-address stack storage: one word per entry, synchronous write,
  read data out of a register one cycle after the read enable.
  Assumes a single clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module stack_mem #(
  parameter int AW = exec_pkg::DEF_STACK_AW,
  parameter int DW = exec_pkg::DEF_PC_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic we,
  input wire logic re,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);

  typedef struct packed {
    logic [(1<<AW)-1:0][DW-1:0] words;
    logic [DW-1:0] rdata;
  } mem_t;

  mem_t m_reg;
  mem_t m_next;

  generate
    if (AW < 1 || AW > 8 || DW < 1) begin : g_bad
      $error("stack_mem: unsupported geometry");
    end
  endgenerate

  always_comb begin
    m_next = m_reg;
    if (we) begin
      m_next.words[addr] = wdata;
    end
    if (re) begin
      m_next.rdata = m_reg.words[addr];
    end
  end

  // Contents are cleared too; cheap at this depth and keeps reads defined
  always_ff @(posedge clock) begin
    if (rst) begin
      m_reg <= '0;
    end else begin
      m_reg <= m_next;
    end
  end

  assign rdata = m_reg.rdata;

endmodule
